/* File: dtl_pkg.sv */
// Package with constants and carrier types for the dual channel dead-time logic
`default_nettype none
package dtl_pkg;

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int DTL_CNT_W = 16;
  localparam logic [DTL_CNT_W-1:0] DTL_CNT_RST = 16'h0000;
  localparam int DTL_SYNC_STAGES = 2;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int DTL_CLK_PERIOD_NS = 20;
  localparam int DTL_NS_PER_KOHM = 10;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic a;
    logic b;
  } dtl_pair_t;

  typedef enum logic [1:0] {
    DTL_ST_IDLE,
    DTL_ST_WAIT,
    DTL_ST_READY
  } dtl_gap_state_t;

endpackage : dtl_pkg
`default_nettype wire

/* File: dtl_sync.sv */
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/10ps
`default_nettype none
module dtl_sync
  import dtl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Data
  input wire logic async_in,
  output logic sync_out
);

  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule : dtl_sync
`default_nettype wire

/* File: dtl_gap_timer.sv */
// Per-channel dead-time timer started by the falling edge of the opposite side
`timescale 1ns/10ps
`default_nettype none
module dtl_gap_timer
  import dtl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Control
  input wire logic start,
  input wire logic [DTL_CNT_W-1:0] dead_cycles,
  // Status
  output logic expired
);

  dtl_gap_state_t state_ff;
  dtl_gap_state_t nxt_state;
  logic [DTL_CNT_W-1:0] cnt_ff;
  logic [DTL_CNT_W-1:0] nxt_cnt;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    if (start) begin
      // A new fall restarts the gap even if one is running
      nxt_cnt = DTL_CNT_RST;
      nxt_state = (dead_cycles <= 16'h0001) ? DTL_ST_READY : DTL_ST_WAIT;
    end else begin
      case (state_ff)
        DTL_ST_IDLE: nxt_state = DTL_ST_READY;
        DTL_ST_WAIT: begin
          nxt_cnt = cnt_ff + 16'h0001;
          if (nxt_cnt >= dead_cycles - 16'h0001) begin
            nxt_state = DTL_ST_READY;
          end
        end
        DTL_ST_READY: nxt_state = DTL_ST_READY;
        default: nxt_state = DTL_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= DTL_ST_IDLE;
      cnt_ff <= DTL_CNT_RST;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  assign expired = (state_ff == DTL_ST_READY);

endmodule : dtl_gap_timer
`default_nettype wire

/* File: dtl_dead_time.sv */
// Top of the dual channel dead-time and shoot-through interlock logic
// Function
// - Pass-through mode: outputs copy inputs, overlap allowed
// - Dead time scales linearly with configured count
// - Input fall starts opposite channel dead time
// - Gap is longer of programmed and input gap
// - Outside pass-through mode, both inputs high forces both outputs low
// - Interlock leaves programmed dead time unchanged
// - B falls, A rises: A waits dead time
// - A falls, B rises: B waits dead time
// - Opposite long low: rising output goes high immediately
// - A rises over high B: B low, A waits
// - B rises over high A: A low, B waits
// - Shutdown input high holds both outputs low
// - Undriven inputs read low only through an external pull-down, then outputs stay low
`timescale 1ns/10ps
`default_nettype none
module dtl_dead_time
  import dtl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Channel inputs from the controller
  input wire logic channel_a_in,
  input wire logic channel_b_in,
  input wire logic output_shutdown_in,
  // Configuration
  input wire logic dead_time_bypass,
  input wire logic [DTL_CNT_W-1:0] dead_time_config,
  // Gate drive outputs
  output logic channel_a_drive,
  output logic channel_b_drive
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Synchronisers reset low and then follow the pin, so nothing here pulls a floating pin low
  dtl_pair_t in_sync;
  logic shutdown_sync;

  dtl_sync u_sync_a (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in(channel_a_in),
    .sync_out(in_sync.a)
  );
  dtl_sync u_sync_b (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in(channel_b_in),
    .sync_out(in_sync.b)
  );
  dtl_sync u_sync_dis (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in(output_shutdown_in),
    .sync_out(shutdown_sync)
  );

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  dtl_pair_t prev_ff;
  dtl_pair_t fall;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prev_ff <= '0;
    end else begin
      prev_ff <= in_sync;
    end
  end

  // ----------------------------------------
  // Dead-time timers
  // ----------------------------------------
  // Timer a guards channel a and is started when b drops, and vice versa.
  // Falls of a drive output are also starts, covering the forced-low case.
  dtl_pair_t drive_ff;
  dtl_pair_t nxt_drive;
  dtl_pair_t ok;
  dtl_pair_t drive_fall;

  // One high-to-low test shared by input and drive edges
  function automatic logic went_low(input logic was_level, input logic now_level);
    return was_level & ~now_level;
  endfunction : went_low

  always_comb begin
    fall.a = went_low(prev_ff.a, in_sync.a);
    fall.b = went_low(prev_ff.b, in_sync.b);
  end

  // Kept apart from the input edges so no process both feeds and reads the decision
  always_comb begin
    drive_fall.a = went_low(drive_ff.a, nxt_drive.a);
    drive_fall.b = went_low(drive_ff.b, nxt_drive.b);
  end

  // The same count is used whatever the interlock did
  dtl_gap_timer u_gap_a (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .start(fall.b | drive_fall.b),
    .dead_cycles(dead_time_config),
    .expired(ok.a)
  );
  dtl_gap_timer u_gap_b (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .start(fall.a | drive_fall.a),
    .dead_cycles(dead_time_config),
    .expired(ok.b)
  );

  // ----------------------------------------
  // Output decision
  // ----------------------------------------
  // Timers run from the input fall, so a long input gap already
  // expired them and the later of the two limits wins.
  always_comb begin
    nxt_drive = '0;
    if (shutdown_sync) begin
      nxt_drive = '0;
    end else if (dead_time_bypass) begin
      nxt_drive = in_sync;
    end else if (in_sync.a & in_sync.b) begin
      nxt_drive = '0;
    end else begin
      nxt_drive.a = in_sync.a & ok.a & ~fall.b;
      nxt_drive.b = in_sync.b & ok.b & ~fall.a;
    end
  end

  // Registered for glitch-free gate drive; costs one cycle of latency
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      drive_ff <= '0;
    end else begin
      drive_ff <= nxt_drive;
    end
  end

  assign channel_a_drive = drive_ff.a;
  assign channel_b_drive = drive_ff.b;

endmodule : dtl_dead_time
`default_nettype wire

/* File: dtl_props.sv */
// Assertion checker for the dead-time logic
`timescale 1ns/10ps
`default_nettype none
module dtl_props
  import dtl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Pins
  input wire logic channel_a_in,
  input wire logic channel_b_in,
  input wire logic output_shutdown_in,
  // Configuration
  input wire logic dead_time_bypass,
  input wire logic [DTL_CNT_W-1:0] dead_time_config,
  // Drives
  input wire logic channel_a_drive,
  input wire logic channel_b_drive
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire logic ia = channel_a_in;
  wire logic ib = channel_b_in;
  wire logic da = channel_a_drive;
  wire logic db = channel_b_drive;
  wire logic sd = output_shutdown_in;
  wire logic byp = dead_time_bypass;
  wire logic [DTL_CNT_W:0] cfg = {1'b0, dead_time_config};
  // Cycles since the opposite drive went low; 17 bits outlast any run
  logic [DTL_CNT_W:0] ga_ff;
  logic [DTL_CNT_W:0] gb_ff;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) ga_ff <= '0;
    else ga_ff <= db ? '0 : ga_ff + 17'h1;
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) gb_ff <= '0;
    else gb_ff <= da ? '0 : gb_ff + 17'h1;
  end
  chk_no_overlap: assert property (!byp |-> !(da && db)) else $error("both drives high");
  chk_shut_low: assert property (sd [*3] |=> !da && !db) else $error("drive in shutdown");
  chk_pass_copy: assert property ((byp && !sd && $stable({ia, ib}))[*4] |-> {da, db} == {ia, ib})
    else $error("bypass copy wrong");
  chk_gap_a: assert property (!byp && $rose(da) |-> ga_ff >= cfg) else $error("a gap short");
  chk_gap_b: assert property (!byp && $rose(db) |-> gb_ff >= cfg) else $error("b gap short");
  chk_fast_a: assert property ((!ib && !sd && cfg < 17'h5)[*8] ##1 (ia && !ib && !sd)[*4] |-> da)
    else $error("a rise late");
  chk_fast_b: assert property ((!ia && !sd && cfg < 17'h5)[*8] ##1 (ib && !ia && !sd)[*4] |-> db)
    else $error("b rise late");
  chk_rise_cause: assert property ($rose(da) |-> $past(ia, 3)) else $error("a rise uncaused");
  cover property (byp && da && db);
  cover property (!byp && $rose(da) && ga_ff > 17'h6);
  cover property (sd && $fell(db));
endmodule : dtl_props
bind dtl_dead_time dtl_props u_props (.*);
`default_nettype wire

/* File: dtl_pwm_model.sv */
// Controller model driving the channel pins
`timescale 1ns/10ps
`default_nettype none
module dtl_pwm_model
  import dtl_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Request
  input wire dtl_pair_t req,
  input wire logic drv_en,
  // Pins
  output var dtl_pair_t pin
);
  // Released pins sit at the pull-down level
  always_ff @(negedge sys_clk) pin <= drv_en ? req : '0;
endmodule : dtl_pwm_model
`default_nettype wire

/* File: test_dtl_dead_time.sv */
// Self-checking bench for the dead-time logic
`timescale 1ns/10ps
`default_nettype none
module test_dtl_dead_time
  import dtl_pkg::*;
;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic shut = 1'b0;
  logic byp = 1'b0;
  logic en = 1'b1;
  logic scored = 1'b0;
  logic [DTL_CNT_W-1:0] cfg = 16'h0004;
  dtl_pair_t req = '0;
  dtl_pair_t pin;
  dtl_pair_t prev = '0;
  dtl_pair_t expq[$];
  wire dtl_pair_t drv;
  int failures = 0;
  int checks_done = 0;
  int n;
  initial forever #10 sys_clk = ~sys_clk;
  dtl_pwm_model i_pwm (.sys_clk(sys_clk), .req(req), .drv_en(en), .pin(pin));
  dtl_dead_time i_dut (.sys_clk(sys_clk), .nrst(nrst), .channel_a_in(pin.a), .channel_b_in(pin.b),
    .output_shutdown_in(shut), .dead_time_bypass(byp), .dead_time_config(cfg),
    .channel_a_drive(drv.a), .channel_b_drive(drv.b));
  task automatic check(input dtl_pair_t seen, input dtl_pair_t exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // v is {shutdown, a, b}; e holds k expected drive changes, oldest first
  task automatic put(input logic [2:0] v, input logic [3:0] e, input int k);
    @(negedge sys_clk);
    req <= dtl_pair_t'(v[1:0]);
    shut <= v[2];
    for (int i = k; i > 0; i--) expq.push_back(dtl_pair_t'(e >> (2 * i - 2)));
    for (n = 0; n < 60 && expq.size() > 0; n++) @(negedge sys_clk);
    if (expq.size() > 0) begin
      failures++;
      wrap_up();
    end
    repeat (12) @(negedge sys_clk);
  endtask : put
  // Every change of the drive pair while scored is set consumes the oldest note
  always @(posedge sys_clk) begin
    #1;
    if (scored && drv !== prev) check(drv, expq.size() > 0 ? expq.pop_front() : prev, "drive");
    prev = drv;
  end
  initial begin
    void'($urandom(32'h494E));
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    scored = 1'b1;
    put(3'h2, 4'h2, 1);
    put(3'h1, 4'h1, 2);
    put(3'h2, 4'h2, 2);
    put(3'h3, 4'h0, 1);
    put(3'h1, 4'h1, 1);
    put(3'h3, 4'h0, 1);
    put(3'h2, 4'h2, 1);
    put(3'h6, 4'h0, 1);
    put(3'h2, 4'h2, 1);
    put(3'h0, 4'h0, 1);
    for (int d = 1; d < 12; d += 3) begin
      cfg = 16'(d);
      put(3'h2, 4'h2, 1);
      put(3'h1, 4'h1, 2);
      check(dtl_pair_t'(n >= d + 3 && n <= d + 5), 2'h1, "gap");
      put(3'h0, 4'h0, 1);
    end
    byp = 1'b1;
    put(3'h3, 4'h3, 1);
    put(3'h0, 4'h0, 1);
    byp = 1'b0;
    en <= 1'b0;
    put(3'h3, 4'h0, 0);
    put(3'h0, 4'h0, 0);
    en <= 1'b1;
    scored = 1'b0;
    repeat (400) begin
      @(negedge sys_clk);
      req <= dtl_pair_t'(2'($urandom));
      shut <= ($urandom % 16) == 0;
    end
    put(3'h0, 4'h0, 0);
    wrap_up();
  end
endmodule : test_dtl_dead_time
`default_nettype wire
